// ===== rtl/fbm_defines.vh
// Notes on behaviour
// - Transmit side pops whole 36-bit long words; later parts come from holding registers.
// - Byte-width transmit: upper nine output lines are don't care, driven zero.
// - Receive side pushes only whole 36-bit long words; partial parts held meanwhile.
// - Edge taking the fourth byte or second word commits the assembled long word.
// - Byte-width receive: upper nine input lines are ignored.
// - Word reads: big-endian gives 35:18 then 17:0; little-endian swaps them.
// - Byte reads, big-endian: 35:27, 26:18, 17:9, 8:0 in that order.
// - Byte reads, little-endian: 8:0, 17:9, 26:18, then 35:27.
// - Word writes: big-endian first word to 35:18; little-endian first word to 17:0.
// - Byte writes fill four lanes, big-endian from 35:27, little-endian from 8:0.
// - Byte order is latched at rising edge of master reset, used by both ports.
// - Width and order take effect once master reset completes, before ready rises.
`ifndef FBM_DEFINES_VH
`define FBM_DEFINES_VH
`define FBM_LONG_W      36
`define FBM_PART_W      18
`define FBM_LANE_W      9
`define FBM_FIFO_DEPTH  8
`define FBM_FIFO_AW     3
`define FBM_POS_LAST_B  2'h3
`define FBM_POS_LAST_W  2'h1
`endif

// ===== rtl/fbm_top.v
`timescale 1ns/1ps
`include "fbm_defines.vh"

// Small valid/ready FIFO, used on the receive path between assembler and wide queue
module fbm_fifo #(
	parameter WIDTH = 36,
	parameter DEPTH = 8,
	parameter AW    = 3
) (
	// Clock and resets
	input  wire             core_clk,
	input  wire             rstn,
	input  wire             clr,
	// Fill side
	input  wire [WIDTH-1:0] in_data,
	input  wire             in_valid,
	output wire             in_ready,
	// Drain side
	output wire [WIDTH-1:0] out_data,
	output wire             out_valid,
	input  wire             out_ready
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW:0]      wr_q;
	reg [AW:0]      rd_q;
	wire            full;
	wire            empty;

	// Full when the pointers meet with their wrap bits apart; saves a fill counter
	assign full      = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
	assign empty     = (wr_q == rd_q);
	assign in_ready  = !full;
	assign out_valid = !empty;
	assign out_data  = mem[rd_q[AW-1:0]];

	// Storage has no reset; only pointers carry state
	always @(posedge core_clk) begin
		if (in_valid && !full)
			mem[wr_q[AW-1:0]] <= in_data;
	end

	// Pointers, one extra bit tells full from empty
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			wr_q <= {(AW+1){1'b0}};
			rd_q <= {(AW+1){1'b0}};
		end else if (clr) begin
			wr_q <= {(AW+1){1'b0}};
			rd_q <= {(AW+1){1'b0}};
		end else begin
			if (in_valid && !full)
				wr_q <= wr_q + 1'b1;
			if (out_ready && !empty)
				rd_q <= rd_q + 1'b1;
		end
	end
endmodule // fbm_fifo

module fbm_top (
	// Clock and reset
	input  wire        core_clk,
	input  wire        rstn,
	// Master and partial resets, active low, synchronous to core_clk
	input  wire        master_reset_first_n,
	input  wire        master_reset_second_n,
	input  wire        partial_reset_n,
	// Static configuration
	input  wire        byte_order_select,
	input  wire        tx_port_width_select,
	input  wire        rx_port_width_select,
	// Long words from the wide_to_tx_queue RAM
	input  wire [35:0] tx_long_data,
	input  wire        tx_long_valid,
	output reg         tx_long_pop,
	// Transmit port
	input  wire        tx_read_en,
	output reg  [17:0] tx_port_data,
	output reg         tx_port_valid,
	// Receive port
	input  wire [17:0] rx_port_data,
	input  wire        rx_write_en,
	output reg         rx_port_ready,
	// Long words into the rx_to_wide_queue RAM
	output reg  [35:0] rx_long_data,
	output reg         rx_long_push,
	input  wire        rx_long_full,
	// Configuration status
	output reg         config_ready,
	output reg         big_endian_q
);
	reg        mr_prev_q;
	reg        tx_byte_q;
	reg        rx_byte_q;
	reg [35:0] tx_hold_q;
	reg [1:0]  tx_pos_q;
	reg        tx_full_q;
	reg [35:0] rx_hold_q;
	reg [1:0]  rx_pos_q;
	reg [17:0] tx_part;
	reg [35:0] tx_hold_d;
	reg [1:0]  tx_pos_d;
	reg        tx_full_d;
	reg [35:0] rx_hold_d;
	reg [1:0]  rx_pos_d;
	wire       tx_load;
	wire       mr_n;
	wire       mr_rise;
	wire       clr;
	wire [1:0] tx_last;
	wire [1:0] rx_last;
	wire       tx_take;
	wire       tx_next;
	wire       rx_take;
	wire       rx_done;
	reg [35:0] rx_merged;
	wire       fifo_in_ready;
	wire [35:0] fifo_out_data;
	wire       fifo_out_valid;
	wire       fifo_drain;

	assign mr_n    = master_reset_first_n & master_reset_second_n;
	assign mr_rise = mr_n && !mr_prev_q;
	assign clr     = !mr_n || !partial_reset_n;
	// Position of the final part of a long word in the selected width
	assign tx_last = tx_byte_q ? `FBM_POS_LAST_B : `FBM_POS_LAST_W;
	assign rx_last = rx_byte_q ? `FBM_POS_LAST_B : `FBM_POS_LAST_W;

	// Configuration capture; order latched on the release edge of master reset
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			mr_prev_q    <= 1'b0;
			big_endian_q <= 1'b0;
			tx_byte_q    <= 1'b0;
			rx_byte_q    <= 1'b0;
			config_ready <= 1'b0;
		end else begin
			mr_prev_q <= mr_n;
			if (mr_rise) begin
				big_endian_q <= byte_order_select;
				tx_byte_q    <= tx_port_width_select;
				rx_byte_q    <= rx_port_width_select;
			end
			// Ready rises a cycle after the release so the selection is already in place
			if (!mr_n)
				config_ready <= 1'b0;
			else if (mr_prev_q)
				config_ready <= 1'b1;
		end
	end

	// A read consumes the shown part; the last part frees the holding register
	assign tx_take = tx_read_en && tx_port_valid;
	assign tx_next = tx_take && (tx_pos_q == tx_last);
	// Refill once the last part goes; the pop guard stops a second pop before the RAM advances
	assign tx_load = config_ready && (!tx_full_q || tx_next) && tx_long_valid && !tx_long_pop;

	// Next transmit state; a fresh long word wins over the release of the old one
	always @* begin
		tx_hold_d = tx_hold_q;
		tx_pos_d  = tx_pos_q;
		tx_full_d = tx_full_q;
		if (tx_load) begin
			tx_hold_d = tx_long_data;
			tx_pos_d  = 2'h0;
			tx_full_d = 1'b1;
		end else if (tx_next) begin
			tx_pos_d  = 2'h0;
			tx_full_d = 1'b0;
		end else if (tx_take) begin
			tx_pos_d  = tx_pos_q + 2'h1;
		end
	end

	// Part selection works on the next state, so a read is followed at once by the next part
	always @* begin
		tx_part = 18'h00000;
		if (tx_byte_q) begin
			// Upper lanes forced low rather than left floating
			case (big_endian_q ? tx_pos_d : ~tx_pos_d)
				2'h0: tx_part[8:0] = tx_hold_d[35:27];
				2'h1: tx_part[8:0] = tx_hold_d[26:18];
				2'h2: tx_part[8:0] = tx_hold_d[17:9];
				2'h3: tx_part[8:0] = tx_hold_d[8:0];
				default: tx_part = 18'h00000;
			endcase
		end else begin
			if (tx_pos_d[0] ^ !big_endian_q)
				tx_part = tx_hold_d[17:0];
			else
				tx_part = tx_hold_d[35:18];
		end
	end

	// Transmit: pop a whole long word, hand it out in parts
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			tx_hold_q     <= 36'h000000000;
			tx_pos_q      <= 2'h0;
			tx_full_q     <= 1'b0;
			tx_long_pop   <= 1'b0;
			tx_port_data  <= 18'h00000;
			tx_port_valid <= 1'b0;
		end else if (clr) begin
			tx_hold_q     <= 36'h000000000;
			tx_pos_q      <= 2'h0;
			tx_full_q     <= 1'b0;
			tx_long_pop   <= 1'b0;
			tx_port_data  <= 18'h00000;
			tx_port_valid <= 1'b0;
		end else begin
			tx_hold_q     <= tx_hold_d;
			tx_pos_q      <= tx_pos_d;
			tx_full_q     <= tx_full_d;
			tx_long_pop   <= tx_load;
			// Valid waits a cycle after a load and drops for the cycle after the last part
			tx_port_valid <= tx_full_q && !tx_next;
			tx_port_data  <= tx_part;
		end
	end

	// Merge the incoming part into the held long word
	always @* begin
		rx_merged = rx_hold_q;
		if (rx_byte_q) begin
			case (big_endian_q ? rx_pos_q : ~rx_pos_q)
				2'h0: rx_merged[35:27] = rx_port_data[8:0];
				2'h1: rx_merged[26:18] = rx_port_data[8:0];
				2'h2: rx_merged[17:9]  = rx_port_data[8:0];
				2'h3: rx_merged[8:0]   = rx_port_data[8:0];
				default: rx_merged = rx_hold_q;
			endcase
		end else begin
			if (rx_pos_q[0] ^ !big_endian_q)
				rx_merged[17:0] = rx_port_data;
			else
				rx_merged[35:18] = rx_port_data;
		end
	end

	assign rx_take = rx_write_en && rx_port_ready;
	assign rx_done = rx_take && (rx_pos_q == rx_last);

	// Next receive state; the final part leaves the holding register empty for the next word
	always @* begin
		rx_hold_d = rx_hold_q;
		rx_pos_d  = rx_pos_q;
		if (rx_done) begin
			rx_hold_d = 36'h000000000;
			rx_pos_d  = 2'h0;
		end else if (rx_take) begin
			rx_hold_d = rx_merged;
			rx_pos_d  = rx_pos_q + 2'h1;
		end
	end

	// Receive: gather parts; final part pushes whole word into the buffer
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rx_hold_q <= 36'h000000000;
			rx_pos_q  <= 2'h0;
		end else if (clr) begin
			rx_hold_q <= 36'h000000000;
			rx_pos_q  <= 2'h0;
		end else begin
			rx_hold_q <= rx_hold_d;
			rx_pos_q  <= rx_pos_d;
		end
	end

	// Buffer absorbs bursts while the wide queue reports full
	fbm_fifo #(
		.WIDTH (`FBM_LONG_W),
		.DEPTH (`FBM_FIFO_DEPTH),
		.AW    (`FBM_FIFO_AW)
	) u_rx_fifo (
		.core_clk  (core_clk),
		.rstn      (rstn),
		.clr       (clr),
		.in_data   (rx_merged),
		.in_valid  (rx_done),
		.in_ready  (fifo_in_ready),
		.out_data  (fifo_out_data),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_drain)
	);

	assign fifo_drain = fifo_out_valid && !rx_long_full;

	// Registered push towards the wide queue; ready stalls the port when the buffer fills
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rx_long_data  <= 36'h000000000;
			rx_long_push  <= 1'b0;
			rx_port_ready <= 1'b0;
		end else begin
			rx_long_push  <= fifo_drain && !clr;
			rx_long_data  <= fifo_out_data;
			// Ready follows the buffer a cycle late; safe, as final parts never fall on
			// neighbouring edges, so no word is offered to a full buffer
			rx_port_ready <= config_ready && !clr && fifo_in_ready;
		end
	end
endmodule // fbm_top

// ===== tb/fbm_top_monitor.sv
`timescale 1ns/1ps
// Port checks for the bus-matching block
module fbm_top_monitor (
	// Clock and resets
	input logic        core_clk,
	input logic        rstn,
	input logic        master_reset_first_n,
	input logic        master_reset_second_n,
	input logic        partial_reset_n,
	// Selects and requests
	input logic        tx_port_width_select,
	input logic        tx_read_en,
	input logic        tx_long_valid,
	// Design outputs
	input logic        tx_long_pop,
	input logic        tx_port_valid,
	input logic        rx_long_push,
	input logic        config_ready,
	input logic        big_endian_q,
	input logic [17:0] tx_port_data
);
	logic mr;
	logic run;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	// No master or partial reset pending
	assign mr  = master_reset_first_n & master_reset_second_n;
	assign run = mr & partial_reset_n;
	sequence s_pop; run && tx_long_pop; endsequence
	sequence s_wait; run && tx_port_valid && !tx_read_en; endsequence
	upper_zero_a: assert property (
		tx_port_valid && tx_port_width_select |-> tx_port_data[17:9] == 9'h000)
		else $error("upper byte lines driven");
	pop_needs_word_a: assert property (tx_long_pop |-> tx_long_valid)
		else $error("pop without a long word");
	pop_single_a: assert property (tx_long_pop |=> !tx_long_pop)
		else $error("two pops in a row");
	pop_then_show_a: assert property (s_pop |=> tx_port_valid)
		else $error("popped word not shown");
	part_holds_a: assert property (s_wait |=> tx_port_valid && $stable(tx_port_data))
		else $error("part changed without a read");
	config_delay_a: assert property ($rose(mr) |-> ##[1:3] config_ready)
		else $error("configuration late");
	// Master reset pulses last longer than four cycles, so this spans steady operation
	order_kept_a: assert property (mr && $past(mr, 4) |-> $stable(big_endian_q))
		else $error("byte order moved");
	part_clear_a: assert property (!partial_reset_n |=> !tx_port_valid && !rx_long_push)
		else $error("partial reset left state");
endmodule // fbm_top_monitor

bind fbm_top fbm_top_monitor u_mon (.core_clk, .rstn, .master_reset_first_n,
	.master_reset_second_n, .partial_reset_n, .tx_port_width_select, .tx_read_en,
	.tx_long_valid, .tx_long_pop, .tx_port_valid, .rx_long_push, .config_ready,
	.big_endian_q, .tx_port_data);

// ===== tb/fbm_tx_model.sv
`timescale 1ns/1ps
// Transmit RAM stand-in: show-ahead long words, stock given by the bench
module fbm_tx_model (
	// Clock and reset
	input  logic        core_clk,
	input  logic        rstn,
	// Long word side
	input  logic [3:0]  add_n,
	input  logic        tx_long_pop,
	output logic [35:0] tx_long_data,
	output logic        tx_long_valid
);
	logic [3:0]  stock_q;
	logic [7:0]  idx_q;
	logic [35:0] word;
	// Idle lines show the inverse, so a stale word never matches
	assign word          = 36'h123456789 + idx_q * 36'h011111111;
	assign tx_long_valid = stock_q != 4'h0;
	assign tx_long_data  = tx_long_valid ? word : ~word;
	// One whole long word leaves per pop
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			stock_q <= 4'h0;
			idx_q   <= 8'h00;
		end else begin
			stock_q <= stock_q + add_n - {3'h0, tx_long_pop};
			idx_q   <= idx_q + {7'h00, tx_long_pop};
		end
	end
endmodule // fbm_tx_model

// ===== tb/tb.sv
`timescale 1ns/1ps
// Bench for the bus-matching block
module tb;
	logic        core_clk, rstn = 0, mr_n = 0, partial_reset_n = 1, byte_order_select = 0;
	logic        tx_port_width_select = 0, rx_port_width_select = 0, tx_read_en = 0;
	logic        rx_write_en = 0, rx_long_full = 0;
	logic [17:0] rx_port_data = 0, tx_port_data;
	logic [3:0]  add_n = 0;
	logic [35:0] tx_long_data, rx_long_data, rxq[$];
	logic        tx_long_valid, tx_long_pop, tx_port_valid, rx_port_ready, rx_long_push;
	logic        config_ready, big_endian_q;
	int          error_cnt, checked, kk;
	fbm_top DUT (.core_clk, .rstn, .master_reset_first_n(mr_n), .master_reset_second_n(mr_n),
		.partial_reset_n, .byte_order_select, .tx_port_width_select, .rx_port_width_select,
		.tx_long_data, .tx_long_valid, .tx_long_pop, .tx_read_en, .tx_port_data, .tx_port_valid,
		.rx_port_data, .rx_write_en, .rx_port_ready, .rx_long_data, .rx_long_push, .rx_long_full,
		.config_ready, .big_endian_q);
	fbm_tx_model u_ram (.core_clk, .rstn, .add_n, .tx_long_pop, .tx_long_data, .tx_long_valid);
	initial begin
		core_clk = 0;
		forever #5 core_clk = ~core_clk;
	end
	// Collect committed long words
	always @(posedge core_clk) if (rx_long_push === 1'b1) rxq.push_back(rx_long_data);
	function automatic logic [35:0] lw(input int k);
		lw = 36'h123456789 + k[7:0] * 36'h011111111;
	endfunction
	// Part i of a long word: lane order follows byte order and width
	function automatic logic [17:0] part(input logic [35:0] L, input int i, input logic be, byt);
		if (byt) part = {9'h000, L[9*(be ? 3-i : i) +: 9]};
		else part = L[18*(be ? 1-i : i) +: 18];
	endfunction
	task automatic check(input string nm, input logic [35:0] seen, input logic [35:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic complete_run;
		$display("mismatches %0d checks %0d", error_cnt, checked);
		if (error_cnt == 0 && checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// Holds request and data until ready is sampled high
	task automatic wr(input logic [17:0] d);
		int w;
		rx_port_data <= d;
		rx_write_en <= 1'b1;
		w = 0;
		do begin @(posedge core_clk); w++; end while (rx_port_ready !== 1'b1 && w < 50);
		check("write taken", rx_port_ready, 1'b1);
	endtask
	task automatic cfg(input logic be, byt);
		@(posedge core_clk);
		mr_n <= 1'b0;
		byte_order_select <= be;
		tx_port_width_select <= byt;
		rx_port_width_select <= byt;
		repeat (5) @(posedge core_clk);
		mr_n <= 1'b1;
		@(posedge core_clk);
		byte_order_select <= ~be; // Latched order must not follow this
		repeat (4) @(negedge core_clk);
		check("order", big_endian_q, be);
		check("ready", config_ready, 1'b1);
	endtask
	task automatic tx_scn(input int n, input logic be, byt);
		int np, j, w;
		np = byt ? 4 : 2;
		j = 0;
		w = 0;
		@(posedge core_clk);
		add_n <= n[3:0];
		tx_read_en <= 1'b1;
		@(posedge core_clk);
		add_n <= 4'h0;
		while (j < n * np && w < 200) begin
			@(negedge core_clk);
			w++;
			if (tx_port_valid === 1'b1) begin
				check("tx part", tx_port_data, part(lw(kk + j / np), j % np, be, byt));
				j++;
			end
		end
		@(posedge core_clk);
		tx_read_en <= 1'b0;
		kk += n;
		check("tx parts", j, n * np);
	endtask
	// Byte mode puts junk on the upper lines, which must be ignored
	task automatic rx_scn(input int n, input logic be, byt);
		rxq.delete();
		@(posedge core_clk);
		for (int k = 0; k < n; k++)
			for (int i = 0; i < (byt ? 4 : 2); i++)
				wr(part(lw(40 + k), i, be, byt) | (byt ? 18'h3FE00 : 18'h00000));
		rx_write_en <= 1'b0;
		repeat (6) @(posedge core_clk);
		check("rx words", rxq.size(), n);
		foreach (rxq[i]) check("rx word", rxq[i], lw(40 + i));
	endtask
	task automatic part_scn;
		rxq.delete();
		@(posedge core_clk);
		wr(18'h00011);
		wr(18'h00022);
		rx_write_en <= 1'b0;
		partial_reset_n <= 1'b0;
		@(posedge core_clk);
		partial_reset_n <= 1'b1;
		@(posedge core_clk);
		for (int i = 0; i < 4; i++) wr(part(lw(60), i, 1'b1, 1'b1));
		rx_write_en <= 1'b0;
		repeat (6) @(posedge core_clk);
		check("rx after clear", rxq.size(), 1);
		check("rx clear word", rxq[0], lw(60));
	endtask
	// Fill the buffer with the drain stalled until writes are refused
	task automatic stall_scn;
		int n;
		cfg(1'b1, 1'b0);
		rxq.delete();
		@(posedge core_clk);
		rx_long_full <= 1'b1;
		for (n = 0; n < 12; n++) begin
			repeat (3) @(posedge core_clk);
			if (rx_port_ready !== 1'b1) break;
			for (int i = 0; i < 2; i++) wr(part(lw(80 + n), i, 1'b1, 1'b0));
			rx_write_en <= 1'b0;
		end
		check("refused", n, 8);
		rx_long_full <= 1'b0;
		repeat (30) @(posedge core_clk);
		check("drained", rxq.size(), n);
		foreach (rxq[i]) check("drained word", rxq[i], lw(80 + i));
	endtask
	initial begin
		repeat (10) @(posedge core_clk);
		rstn <= 1'b1;
		for (int b = 0; b < 2; b++)
			for (int s = 0; s < 2; s++) begin
				cfg(b[0], s[0]);
				tx_scn(2, b[0], s[0]);
				rx_scn(2, b[0], s[0]);
			end
		part_scn;
		stall_scn;
		complete_run;
	end
	// The run needs about 250 cycles; the limit of 10000 cycles is forty times that and means a hang
	initial begin
		#100000;
		error_cnt++;
		complete_run;
	end
endmodule // tb
